/* File: src/pfs_fault_supervisor.sv */
`timescale 1ns/10ps
`include "pfs_cfg.svh"

module pfs_fault_supervisor
    import pfs_pkg::*;
#(
    parameter int BLANK_CYC    = `PFS_BLANK_CYC,
    parameter int WINDOW_CYC   = `PFS_WINDOW_CYC,
    parameter int RT_BLANK_CYC = `PFS_RT_BLANK_CYC
) (
    input  wire logic MCLK,
    input  wire logic RESET,
    input  wire logic BROWNOUT_COMPARATOR_OUT,
    input  wire logic BROWNOUT_SENSE_OUT,
    input  wire logic SUPPLY_ABOVE_ON,
    input  wire logic SUPPLY_BELOW_OFF,
    input  wire logic TEMP_ABOVE_UPPER,
    input  wire logic TEMP_BELOW_LOWER,
    input  wire logic TIMING_CURRENT_LOW,
    input  wire logic OUTPUT_UNDERVOLTAGE_FAULT,
    input  wire logic LATCH_OFF_REQ,
    input  wire logic STARTUP_PHASE_FLAG,
    input  wire logic PHASE_A_REQ,
    input  wire logic PHASE_B_REQ,
    output logic      CLAMP_SWITCH,
    output logic      HYSTERESIS_SINK_CURRENT,
    output logic      SENSE_PULLDOWN,
    output logic      BROWNOUT_FAULT,
    output logic      BROWNOUT_EVENT_LATCH,
    output logic      THERMAL_SHUTDOWN,
    output logic      SUPPLY_LOCKOUT,
    output logic      TIMING_PIN_OPEN_FAULT,
    output logic      CIRCUIT_OFF,
    output logic      CONTROL_GROUND,
    output logic      GATE_A,
    output logic      GATE_B,
    output logic      SUPPLY_READY_OUT
);

    // ------------------------------------------------------------------
    // Counter widths
    // ------------------------------------------------------------------
    // One count of headroom so every terminal value fits its counter
    localparam int BW = $clog2(BLANK_CYC + 1);
    localparam int WW = $clog2(WINDOW_CYC + 1);
    localparam int RW = $clog2(RT_BLANK_CYC + 1);

    // Brown-out sequence state and its timers
    pfs_bo_state_e    bo_state;
    logic [BW-1:0]    blank_cnt;
    logic [WW-1:0]    window_cnt;
    logic [RW-1:0]    rt_cnt;

    // Hysteresis sink and the gathered shutdown sources
    logic             sink_on;
    pfs_fault_s       faults;

    // Decoded sequence events
    logic             blank_done;
    logic             window_done;
    logic             bo_start;
    logic             bo_hit;
    logic             window_end;
    logic             rt_full;
    logic             next_gate_a;
    logic             next_gate_b;
    logic             next_ground;
    logic             next_ready;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Terminal count test shared by all three timers; ints avoid width games
    function automatic logic at_count(input int cnt, input int limit);
        return cnt == limit;
    endfunction

    // A phase request reaches its gate only while the circuit is on
    function automatic logic gate_drive(input logic req, input logic off);
        return req && !off;
    endfunction

    // ------------------------------------------------------------------
    // Supply lockout with hysteresis
    // ------------------------------------------------------------------
    // Lockout set on reset; thresholds are compared outside the block.
    // Two separate levels give the hysteresis: a supply hovering near one
    // level cannot make the circuit chatter on and off.
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            SUPPLY_LOCKOUT <= `PFS_RST_LOCKOUT;
        end else if (SUPPLY_LOCKOUT && SUPPLY_ABOVE_ON) begin
            SUPPLY_LOCKOUT <= 1'b0;
        end else if (!SUPPLY_LOCKOUT && SUPPLY_BELOW_OFF) begin
            SUPPLY_LOCKOUT <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Thermal shutdown hysteresis
    // ------------------------------------------------------------------
    // Reset leaves the upper threshold active, so cold starts are safe
    // Trip and release use separate comparators; the state holds between
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            THERMAL_SHUTDOWN <= `PFS_RST_THERMAL;
        end else if (!THERMAL_SHUTDOWN && TEMP_ABOVE_UPPER) begin
            THERMAL_SHUTDOWN <= 1'b1;
        end else if (THERMAL_SHUTDOWN && TEMP_BELOW_LOWER) begin
            THERMAL_SHUTDOWN <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Timing-pin open detection
    // ------------------------------------------------------------------
    // Blanking filter rejects short dips in the timing current
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            rt_cnt <= '0;
        end else if (!TIMING_CURRENT_LOW) begin
            rt_cnt <= '0;
        end else if (!rt_full) begin
            rt_cnt <= rt_cnt + 1'b1;
        end
    end

    // Saturates at the limit so a long open pin cannot wrap the filter
    assign rt_full = at_count(int'(rt_cnt), RT_BLANK_CYC);

    // Set wins over clear: a persisting open pin stays flagged
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            TIMING_PIN_OPEN_FAULT <= `PFS_RST_TIMING_OPEN;
        end else if (rt_full) begin
            TIMING_PIN_OPEN_FAULT <= 1'b1;
        end else if (SUPPLY_LOCKOUT) begin
            TIMING_PIN_OPEN_FAULT <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Brown-out qualification
    // ------------------------------------------------------------------
    assign blank_done  = at_count(int'(blank_cnt), BLANK_CYC - 1);
    assign window_done = at_count(int'(window_cnt), WINDOW_CYC - 1);
    // Comparator is heard only when idle and not already in fault
    assign bo_start    = (bo_state == PFS_BO_IDLE) && BROWNOUT_COMPARATOR_OUT
                         && !BROWNOUT_FAULT;
    // Sense high anywhere in the window is a detection
    assign bo_hit      = (bo_state == PFS_BO_WINDOW) && BROWNOUT_SENSE_OUT;
    // The window closes on expiry or on detection, whichever comes first
    assign window_end  = (bo_state == PFS_BO_WINDOW) && (bo_hit || window_done);

    // Sequence: idle, blanking, detection window; lockout aborts all.
    // The comparator may toggle freely during blanking and the window; only
    // the sense output and the timers decide, which is what gives hold-up time.
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            bo_state <= PFS_BO_IDLE;
        end else begin
            unique case (bo_state)
                PFS_BO_IDLE: begin
                    if (bo_start) begin
                        bo_state <= PFS_BO_BLANK;
                    end
                end
                PFS_BO_BLANK: begin
                    if (blank_done) begin
                        bo_state <= PFS_BO_WINDOW;
                    end
                end
                PFS_BO_WINDOW: begin
                    if (window_end) begin
                        bo_state <= PFS_BO_IDLE;
                    end
                end
                default: begin
                    bo_state <= PFS_BO_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Brown-out timers
    // ------------------------------------------------------------------
    // Blanking timer; the full nominal count keeps it above its minimum
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            blank_cnt <= '0;
        end else if (bo_state != PFS_BO_BLANK || blank_done) begin
            blank_cnt <= '0;
        end else begin
            blank_cnt <= blank_cnt + 1'b1;
        end
    end

    // Window timer; detection or expiry returns it to zero
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            window_cnt <= '0;
        end else if (bo_state != PFS_BO_WINDOW || window_end) begin
            window_cnt <= '0;
        end else begin
            window_cnt <= window_cnt + 1'b1;
        end
    end

    // Event latch: first comparator high sets it, window end clears it
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            BROWNOUT_EVENT_LATCH <= `PFS_RST_EVENT_LATCH;
        end else if (bo_start) begin
            BROWNOUT_EVENT_LATCH <= 1'b1;
        end else if (window_end) begin
            BROWNOUT_EVENT_LATCH <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Brown-out fault and hysteresis sink
    // ------------------------------------------------------------------
    // Fault flag starts high; cleared only once the comparator output falls
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            BROWNOUT_FAULT <= `PFS_RST_BO_FAULT;
        end else if (bo_hit) begin
            BROWNOUT_FAULT <= 1'b1;
        end else if (BROWNOUT_FAULT && !BROWNOUT_COMPARATOR_OUT) begin
            BROWNOUT_FAULT <= 1'b0;
        end
    end

    // Sink current: on from supply-on until the pin rises above threshold.
    // Re-arming it on detection pulls the pin clear of the comparator edge.
    always_ff @(posedge MCLK) begin
        if (RESET || SUPPLY_LOCKOUT) begin
            sink_on <= `PFS_RST_SINK;
        end else if (bo_hit) begin
            sink_on <= 1'b1;
        end else if (!BROWNOUT_COMPARATOR_OUT) begin
            sink_on <= 1'b0;
        end
    end

    // Clamp only while comparator high and no fault holds it open.
    // Holding the pin just under threshold lets line recovery show at once,
    // without waiting for the filter capacitor to recharge.
    assign CLAMP_SWITCH            = BROWNOUT_COMPARATOR_OUT && !BROWNOUT_FAULT;
    // Sink stays quiet in lockout; the pull-down holds the pin there instead
    assign HYSTERESIS_SINK_CURRENT = sink_on && !SUPPLY_LOCKOUT;
    assign SENSE_PULLDOWN          = SUPPLY_LOCKOUT;

    // ------------------------------------------------------------------
    // Circuit off and outputs
    // ------------------------------------------------------------------
    // Brown-out and timing-pin faults come from this block's own latches
    assign faults.brownout     = BROWNOUT_FAULT;
    assign faults.timing_open  = TIMING_PIN_OPEN_FAULT;

    // External faults pass straight through; their sources hold them
    assign faults.undervoltage = OUTPUT_UNDERVOLTAGE_FAULT;
    assign faults.latch_off    = LATCH_OFF_REQ;

    // Thermal and lockout come from the hysteresis stages above
    assign faults.thermal      = THERMAL_SHUTDOWN;
    assign faults.lockout      = SUPPLY_LOCKOUT;

    // No filtering here: every source is already a clean level
    assign CIRCUIT_OFF         = |faults;

    // ------------------------------------------------------------------
    // Gate, control and ready drivers
    // ------------------------------------------------------------------
    // Next output levels; each falls back to its safe level while off
    always_comb begin
        next_gate_a = gate_drive(PHASE_A_REQ, CIRCUIT_OFF);
        next_gate_b = gate_drive(PHASE_B_REQ, CIRCUIT_OFF);
        next_ground = CIRCUIT_OFF;
        next_ready  = !CIRCUIT_OFF && !STARTUP_PHASE_FLAG;
    end

    // Phase A driver; registered so a glitch on the fault OR never reaches it
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            GATE_A <= `PFS_RST_GATE;
        end else begin
            GATE_A <= next_gate_a;
        end
    end

    // Phase B driver, same treatment
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            GATE_B <= `PFS_RST_GATE;
        end else begin
            GATE_B <= next_gate_b;
        end
    end

    // Control node grounded while off, so a restart goes through soft-start
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            CONTROL_GROUND <= `PFS_RST_CTL_GROUND;
        end else begin
            CONTROL_GROUND <= next_ground;
        end
    end

    // Ready to the downstream converter; also held low through start-up
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            SUPPLY_READY_OUT <= `PFS_RST_READY;
        end else begin
            SUPPLY_READY_OUT <= next_ready;
        end
    end

endmodule // pfs_fault_supervisor

/* File: common/pfs_cfg.svh */
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
// Clock rate in kHz
`define PFS_CLK_KHZ          40000
// Brown-out blanking, nominal, in ms
`define PFS_BLANK_MS         50
// Brown-out detection window, nominal, in ms
`define PFS_WINDOW_MS        50
// Timing-pin open blanking, in us
`define PFS_RT_BLANK_US      30
// Cycle counts derived from the rate
`define PFS_BLANK_CYC        (`PFS_BLANK_MS * `PFS_CLK_KHZ)
`define PFS_WINDOW_CYC       (`PFS_WINDOW_MS * `PFS_CLK_KHZ)
`define PFS_RT_BLANK_CYC     ((`PFS_RT_BLANK_US * `PFS_CLK_KHZ + 999) / 1000)
// Reset values of the held flags and outputs
`define PFS_RST_LOCKOUT      1'b1
`define PFS_RST_BO_FAULT     1'b1
`define PFS_RST_EVENT_LATCH  1'b0
`define PFS_RST_SINK         1'b1
`define PFS_RST_THERMAL      1'b0
`define PFS_RST_TIMING_OPEN  1'b0
`define PFS_RST_GATE         1'b0
`define PFS_RST_CTL_GROUND   1'b1
`define PFS_RST_READY        1'b0
`endif

/* File: common/pfs_pkg.sv */
package pfs_pkg;
    // Brown-out qualification sequence
    typedef enum logic [2:0] {
        PFS_BO_IDLE   = 3'b001,
        PFS_BO_BLANK  = 3'b010,
        PFS_BO_WINDOW = 3'b100
    } pfs_bo_state_e;

    // Shutdown sources gathered together
    typedef struct packed {
        logic brownout;
        logic undervoltage;
        logic latch_off;
        logic thermal;
        logic timing_open;
        logic lockout;
    } pfs_fault_s;
endpackage

/* File: sim/pfs_fault_supervisor_properties.sv */
`timescale 1ns/10ps
// ------
// Supervisor checker
// ------
module pfs_fault_checker
    import pfs_pkg::*;
(
    input wire logic MCLK,
    input wire logic RESET,
    input wire logic BROWNOUT_COMPARATOR_OUT,
    input wire logic SUPPLY_ABOVE_ON,
    input wire logic CLAMP_SWITCH,
    input wire logic TEMP_ABOVE_UPPER,
    input wire logic OUTPUT_UNDERVOLTAGE_FAULT,
    input wire logic LATCH_OFF_REQ,
    input wire logic BROWNOUT_FAULT,
    input wire logic BROWNOUT_EVENT_LATCH,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic SUPPLY_LOCKOUT,
    input wire logic CIRCUIT_OFF,
    input wire logic TIMING_PIN_OPEN_FAULT,
    input wire logic CONTROL_GROUND,
    input wire logic GATE_A,
    input wire logic GATE_B,
    input wire logic SUPPLY_READY_OUT
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    // Both gates and ready low
    sequence s_dark; !GATE_A && !GATE_B && !SUPPLY_READY_OUT; endsequence
    // Blanking is far longer than eight cycles
    sequence s_quiet; !BROWNOUT_FAULT [*8]; endsequence
    property p_clamp; BROWNOUT_COMPARATOR_OUT && !BROWNOUT_FAULT |-> CLAMP_SWITCH; endproperty
    property p_open; BROWNOUT_FAULT |-> !CLAMP_SWITCH; endproperty
    property p_blank; $rose(BROWNOUT_EVENT_LATCH) |-> s_quiet; endproperty
    property p_off; BROWNOUT_FAULT || THERMAL_SHUTDOWN || SUPPLY_LOCKOUT
        || TIMING_PIN_OPEN_FAULT || OUTPUT_UNDERVOLTAGE_FAULT || LATCH_OFF_REQ
        |-> CIRCUIT_OFF; endproperty
    property p_gate; CIRCUIT_OFF |=> s_dark; endproperty
    property p_ctl; CIRCUIT_OFF |=> CONTROL_GROUND; endproperty
    property p_heat; $rose(THERMAL_SHUTDOWN) |-> $past(TEMP_ABOVE_UPPER); endproperty
    property p_rt; $fell(TIMING_PIN_OPEN_FAULT) |-> $past(SUPPLY_LOCKOUT); endproperty
    property p_lock; $fell(SUPPLY_LOCKOUT) |-> $past(SUPPLY_ABOVE_ON); endproperty
    a_clamp: assert property (p_clamp) else $error("clamp not closed");
    a_open: assert property (p_open) else $error("clamp closed in fault");
    a_blank: assert property (p_blank) else $error("fault in blanking");
    a_off: assert property (p_off) else $error("circuit not off");
    a_gate: assert property (p_gate) else $error("gate or ready high when off");
    a_ctl: assert property (p_ctl) else $error("control not grounded");
    a_heat: assert property (p_heat) else $error("thermal trip without cause");
    a_rt: assert property (p_rt) else $error("timing fault cleared outside lockout");
    a_lock: assert property (p_lock) else $error("lockout left below turn-on");
endmodule // pfs_fault_checker

bind pfs_fault_supervisor pfs_fault_checker ck_u (.MCLK, .RESET, .BROWNOUT_COMPARATOR_OUT,
    .SUPPLY_ABOVE_ON, .CLAMP_SWITCH, .TEMP_ABOVE_UPPER, .OUTPUT_UNDERVOLTAGE_FAULT,
    .LATCH_OFF_REQ, .BROWNOUT_FAULT, .BROWNOUT_EVENT_LATCH,
    .THERMAL_SHUTDOWN, .SUPPLY_LOCKOUT, .CIRCUIT_OFF, .TIMING_PIN_OPEN_FAULT, .CONTROL_GROUND,
    .GATE_A, .GATE_B, .SUPPLY_READY_OUT);

/* File: sim/pfs_downstream_model.sv */
`timescale 1ns/10ps
module pfs_downstream_model
    import pfs_pkg::*;
(
    input  wire logic mclk,
    input  wire logic ready,
    output logic      running
);
    // Converter runs only on ready, stops a cycle after it drops
    always_ff @(posedge mclk) begin
        running <= ready;
    end
endmodule // pfs_downstream_model

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb
    import pfs_pkg::*;
    ;
    localparam int BLK = 20;
    localparam int WIN = 20;
    localparam int RTB = 5;
    logic mclk = 1'h0, rst = 1'h1, comp = 1'h1, sense = 1'h0, son = 1'h0, soff = 1'h1;
    logic thi = 1'h0, tlo = 1'h1, tcl = 1'h0, output_undervoltage_fault = 1'h0, loff = 1'h0, startup_phase_flag = 1'h1;
    logic pa = 1'h0, pb = 1'h0, run, clamp, sink, bof, bol, thermal_shutdown, lock, rto, off, cg, ga, rdy;
    logic gb, spd;
    int   failures = 0, n_checks = 0;
    // ------
    // Clock, design and partner
    // ------
    always #12.5 mclk = ~mclk;
    pfs_fault_supervisor #(.BLANK_CYC(BLK), .WINDOW_CYC(WIN), .RT_BLANK_CYC(RTB)) dut_u (
        .MCLK(mclk), .RESET(rst), .BROWNOUT_COMPARATOR_OUT(comp), .BROWNOUT_SENSE_OUT(sense),
        .SUPPLY_ABOVE_ON(son), .SUPPLY_BELOW_OFF(soff), .TEMP_ABOVE_UPPER(thi),
        .TEMP_BELOW_LOWER(tlo), .TIMING_CURRENT_LOW(tcl), .OUTPUT_UNDERVOLTAGE_FAULT(output_undervoltage_fault),
        .LATCH_OFF_REQ(loff), .STARTUP_PHASE_FLAG(startup_phase_flag), .PHASE_A_REQ(pa), .PHASE_B_REQ(pb),
        .CLAMP_SWITCH(clamp), .HYSTERESIS_SINK_CURRENT(sink), .SENSE_PULLDOWN(spd),
        .BROWNOUT_FAULT(bof), .BROWNOUT_EVENT_LATCH(bol), .THERMAL_SHUTDOWN(thermal_shutdown),
        .SUPPLY_LOCKOUT(lock), .TIMING_PIN_OPEN_FAULT(rto), .CIRCUIT_OFF(off),
        .CONTROL_GROUND(cg), .GATE_A(ga), .GATE_B(gb), .SUPPLY_READY_OUT(rdy));
    pfs_downstream_model down_u (.mclk(mclk), .ready(rdy), .running(run));
    // Inputs move only on falling edges
    task automatic w(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        w(8);
        rst = 1'h0;
        w(1);
        chk(bof, 1'h1);
        chk(lock, 1'h1);
        chk(ga, 1'h0);
        chk(gb, 1'h0);
        chk(spd, 1'h1);
        son = 1'h1; soff = 1'h0; pa = 1'h1; pb = 1'h1;
        w(3);
        chk(lock, 1'h0);
        chk(spd, 1'h0);
        chk(sink, 1'h1);
        comp = 1'h0;
        w(3);
        chk(bof, 1'h0);
        chk(sink, 1'h0);
        chk(rdy, 1'h0);
        startup_phase_flag = 1'h0;
        w(3);
        chk(rdy, 1'h1);
        chk(run, 1'h1);
        chk(ga, 1'h1);
        chk(gb, 1'h1);
        // Short interruption is blanked
        comp = 1'h1;
        w(2);
        chk(clamp, 1'h1);
        chk(bol, 1'h1);
        comp = 1'h0;
        repeat (BLK + WIN + 4) begin
            w(1);
            chk(rdy, 1'h1);
        end
        chk(bol, 1'h0);
        chk(bof, 1'h0);
        // Real brown-out, sense high mid-blanking
        comp = 1'h1;
        w(BLK / 2);
        sense = 1'h1;
        w(BLK / 2 - 3);
        chk(bof, 1'h0);
        w(8);
        chk(bof, 1'h1);
        chk(clamp, 1'h0);
        chk(sink, 1'h1);
        chk(bol, 1'h0);
        w(2);
        chk(cg, 1'h1);
        chk(ga, 1'h0);
        chk(gb, 1'h0);
        chk(run, 1'h0);
        sense = 1'h0; comp = 1'h0;
        w(4);
        chk(rdy, 1'h1);
        // Thermal hysteresis, then reset mid-trip
        thi = 1'h1; tlo = 1'h0;
        w(3);
        chk(ga, 1'h0);
        thi = 1'h0;
        w(3);
        chk(thermal_shutdown, 1'h1);
        tlo = 1'h1;
        w(2);
        chk(thermal_shutdown, 1'h0);
        thi = 1'h1; tlo = 1'h0;
        w(2);
        thi = 1'h0; rst = 1'h1;
        w(2);
        rst = 1'h0;
        w(4);
        chk(thermal_shutdown, 1'h0);
        // Timing pin blanking and latch
        tcl = 1'h1; w(RTB - 2); tcl = 1'h0; w(2);
        chk(rto, 1'h0);
        tcl = 1'h1; w(RTB + 4); tcl = 1'h0; w(2);
        chk(rto, 1'h1);
        chk(off, 1'h1);
        son = 1'h0;
        w(3);
        chk(lock, 1'h0);
        soff = 1'h1;
        w(3);
        chk(rto, 1'h0);
        son = 1'h1; soff = 1'h0;
        w(4);
        for (int i = 0; i < 2; i++) begin
            {output_undervoltage_fault, loff} = 2'h1 << i;
            w(3);
            chk(rdy, 1'h0);
            {output_undervoltage_fault, loff} = 2'h0;
            w(3);
            chk(off, 1'h0);
        end
        finish_test();
    end
    // Watchdog: the sequence needs some 150 cycles
    initial begin
        #(25 * 1000);
        failures++;
        finish_test();
    end
endmodule // tb
